// ===== shared/pts_params.svh
// Constants for the precision-time system clock and transmit stamp block.
// Assumes inclusion by bare name from the design and testbench files.
// Function
// - Valid flag set on capture, cleared reading high
// - Control bit 4 enables transmit stamping
// - Packet mode advances time once per stamp
// - Packet mode ignores the increment period
// - Adjustment applied on the next clock
// - Stamp held in two read-only words
// - System time is two 32-bit words
// - Increment value 23:0, period 31:24
// - Adjustment: low word, magnitude, sign bit
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH

// Register byte addresses
`define PTS_ADDR_W          17
`define PTS_OFF_TIME_LO     17'h0b600
`define PTS_OFF_TIME_HI     17'h0b604
`define PTS_OFF_INC_ATTR    17'h0b608
`define PTS_OFF_ADJ_LO      17'h0b60c
`define PTS_OFF_ADJ_HI      17'h0b610
`define PTS_OFF_TX_CTRL     17'h0b614
`define PTS_OFF_TX_LO       17'h0b618
`define PTS_OFF_TX_HI       17'h0b61c
`define PTS_OFF_IRQ_STAT    17'h0b640
`define PTS_OFF_IRQ_MASK    17'h0b644

// Field positions
`define PTS_CTRL_VALID_BIT  0
`define PTS_CTRL_EN_BIT     4
`define PTS_CTRL_PKT_BIT    5
`define PTS_INC_VAL_MSB     23
`define PTS_INC_PER_LSB     24
`define PTS_ADJ_SIGN_BIT    31

// Interrupt status bits
`define PTS_IRQ_CAPTURE_BIT 0
`define PTS_IRQ_ADJUST_BIT  1
`define PTS_IRQ_W           2

// Reset values
`define PTS_RST_WORD        32'h0000_0000

`endif

// ===== shared/pts_pkg.sv
// Types for the precision-time system clock and transmit stamp block.
// Constants live in the params header.
package pts_pkg;
    typedef logic [31:0] pts_word_t;
    typedef logic [63:0] pts_time_t;
    typedef enum logic [1:0] {
        PTS_RESP_OKAY   = 2'b00,
        PTS_RESP_SLVERR = 2'b10
    } pts_resp_t;
endpackage : pts_pkg

// ===== verilog/pts_reset_sync.sv
// Reset release synchroniser.
// Assumes an asynchronous active-low reset from the chip.
`timescale 1ns/1ps
`default_nettype none
module pts_reset_sync (
    // Clock and raw reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Synchronised reset
    output var  logic rst_sync_n
);
    logic stage_q;

    // Assert at once, release after two edges to avoid metastable release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_q    <= 1'b1;
            rst_sync_n <= stage_q;
        end
    end
endmodule : pts_reset_sync
`default_nettype wire

// ===== verilog/pts_time_core.sv
// Running 64-bit system time with period or packet advance and adjust.
// Assumes one clock domain; load, adjust and packet strobes are pulses.
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module pts_time_core #(
    parameter int VAL_W = 24,
    parameter int PER_W = 8
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Configuration
    input  wire logic [VAL_W-1:0]  inc_value,
    input  wire logic [PER_W-1:0]  inc_period,
    input  wire logic              pkt_mode,
    // Events
    input  wire logic              pkt_stamp,
    input  wire logic              adj_go,
    input  wire pts_pkg::pts_time_t adj_mag,
    input  wire logic              adj_sub,
    input  wire logic              load_lo,
    input  wire logic              load_hi,
    input  wire pts_pkg::pts_word_t load_data,
    // Time out
    output var  pts_pkg::pts_time_t time_q
);
    import pts_pkg::*;

    logic [PER_W-1:0] tick_q;
    logic             adv;
    pts_time_t        step;
    pts_time_t        time_d;

    // Period counter; a period of zero never advances in normal mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= '0;
        end else if (pkt_mode || inc_period == '0) begin
            tick_q <= '0;
        end else if (tick_q + 1'b1 >= inc_period) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // Advance source chosen by mode
    always_comb begin
        if (pkt_mode) begin
            adv = pkt_stamp;
        end else begin
            adv = (inc_period != '0) &&
                  (tick_q + 1'b1 >= inc_period);
        end
        step = adv ? pts_time_t'(inc_value) : '0;
        time_d = time_q + step;
        if (adj_go) begin
            time_d = adj_sub ? time_d - adj_mag
                             : time_d + adj_mag;
        end
        if (load_lo) begin
            time_d[31:0] = load_data;
        end
        if (load_hi) begin
            time_d[63:32] = load_data;
        end
    end

    // Time register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            time_q <= '0;
        end else begin
            time_q <= time_d;
        end
    end
endmodule : pts_time_core
`default_nettype wire

// ===== verilog/pts_stamp_top.sv
// Precision-time block top: AXI4-Lite registers, time core, tx stamp.
// Assumes tx_pkt_stamp is a one-cycle pulse from sys_clk domain logic.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module pts_stamp_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // AXI4-Lite write address
    input  wire logic [16:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [16:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Transmit path
    input  wire logic        tx_pkt_stamp,
    // Interrupt
    output var  logic        irq
);
    import pts_pkg::*;

    logic        rst_n;
    logic [16:0] aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_go;
    pts_word_t   wr_val;
    pts_word_t   inc_attr_q;
    pts_word_t   adj_lo_q;
    pts_word_t   adj_hi_q;
    logic        adj_go_q;
    logic        en_q;
    logic        pkt_q;
    logic        valid_q;
    pts_time_t   stamp_q;
    pts_time_t   sys_time;
    logic        capture;
    logic        rd_go;
    logic        rd_hit;
    pts_word_t   rd_val;
    logic        hi_read;
    logic [`PTS_IRQ_W-1:0] stat_q;
    logic [`PTS_IRQ_W-1:0] mask_q;
    logic [`PTS_IRQ_W-1:0] evt;

    // Byte-lane merge of write data with the current register value
    function automatic pts_word_t merge(input pts_word_t old,
                                        input pts_word_t nw,
                                        input logic [3:0] strb);
        pts_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address match used by both read and write decode
    function automatic logic hit(input logic [16:0] a,
                                 input logic [16:0] off);
        return a[16:2] == off[16:2];
    endfunction : hit

    pts_reset_sync u_rst (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .rst_sync_n (rst_n)
    );

    // Write address and data accepted in either order, held until both
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    // Ready is registered so every output comes from a flip-flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (hit(aw_addr_q, `PTS_OFF_TIME_LO) ||
                             hit(aw_addr_q, `PTS_OFF_TIME_HI) ||
                             hit(aw_addr_q, `PTS_OFF_INC_ATTR) ||
                             hit(aw_addr_q, `PTS_OFF_ADJ_LO) ||
                             hit(aw_addr_q, `PTS_OFF_ADJ_HI) ||
                             hit(aw_addr_q, `PTS_OFF_TX_CTRL) ||
                             hit(aw_addr_q, `PTS_OFF_TX_LO) ||
                             hit(aw_addr_q, `PTS_OFF_TX_HI) ||
                             hit(aw_addr_q, `PTS_OFF_IRQ_STAT) ||
                             hit(aw_addr_q, `PTS_OFF_IRQ_MASK))
                            ? PTS_RESP_OKAY : PTS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inc_attr_q <= `PTS_RST_WORD;
            adj_lo_q   <= `PTS_RST_WORD;
            adj_hi_q   <= `PTS_RST_WORD;
            en_q       <= 1'b0;
            pkt_q      <= 1'b0;
            mask_q     <= '0;
        end else if (wr_go) begin
            if (hit(aw_addr_q, `PTS_OFF_INC_ATTR)) begin
                inc_attr_q <= merge(inc_attr_q, w_data_q, w_strb_q);
            end
            if (hit(aw_addr_q, `PTS_OFF_ADJ_LO)) begin
                adj_lo_q <= merge(adj_lo_q, w_data_q, w_strb_q);
            end
            if (hit(aw_addr_q, `PTS_OFF_ADJ_HI)) begin
                adj_hi_q <= wr_val;
            end
            if (hit(aw_addr_q, `PTS_OFF_TX_CTRL) && w_strb_q[0]) begin
                en_q  <= w_data_q[`PTS_CTRL_EN_BIT];
                pkt_q <= w_data_q[`PTS_CTRL_PKT_BIT];
            end
            if (hit(aw_addr_q, `PTS_OFF_IRQ_MASK) && w_strb_q[0]) begin
                mask_q <= w_data_q[`PTS_IRQ_W-1:0];
            end
        end
    end

    assign wr_val = merge(adj_hi_q, w_data_q, w_strb_q);

    // Writing the high adjust word launches the adjustment next clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adj_go_q <= 1'b0;
        end else begin
            adj_go_q <= wr_go && hit(aw_addr_q, `PTS_OFF_ADJ_HI);
        end
    end

    pts_time_core #(
        .VAL_W (24),
        .PER_W (8)
    ) u_core (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .inc_value  (inc_attr_q[`PTS_INC_VAL_MSB:0]),
        .inc_period (inc_attr_q[31:`PTS_INC_PER_LSB]),
        .pkt_mode   (pkt_q),
        .pkt_stamp  (capture),
        .adj_go     (adj_go_q),
        .adj_mag    ({1'b0, adj_hi_q[30:0], adj_lo_q}),
        .adj_sub    (adj_hi_q[`PTS_ADJ_SIGN_BIT]),
        .load_lo    (wr_go && hit(aw_addr_q, `PTS_OFF_TIME_LO)),
        .load_hi    (wr_go && hit(aw_addr_q, `PTS_OFF_TIME_HI)),
        .load_data  (w_data_q),
        .time_q     (sys_time)
    );

    // Stamp taken only when enabled and no unread stamp is held
    assign capture = tx_pkt_stamp && en_q && !valid_q;
    assign hi_read = rd_go && hit(s_axi_araddr, `PTS_OFF_TX_HI);

    // Stamp words and valid flag; a capture wins over a clearing read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_q <= '0;
            valid_q <= 1'b0;
        end else if (capture) begin
            stamp_q <= sys_time;
            valid_q <= 1'b1;
        end else if (hi_read) begin
            valid_q <= 1'b0;
        end
    end

    // Read channel; one-cycle latency from address acceptance
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        case (1'b1)
            hit(s_axi_araddr, `PTS_OFF_TIME_LO):  rd_val = sys_time[31:0];
            hit(s_axi_araddr, `PTS_OFF_TIME_HI):  rd_val = sys_time[63:32];
            hit(s_axi_araddr, `PTS_OFF_INC_ATTR): rd_val = inc_attr_q;
            hit(s_axi_araddr, `PTS_OFF_ADJ_LO):   rd_val = adj_lo_q;
            hit(s_axi_araddr, `PTS_OFF_ADJ_HI):   rd_val = adj_hi_q;
            hit(s_axi_araddr, `PTS_OFF_TX_CTRL): begin
                rd_val[`PTS_CTRL_VALID_BIT] = valid_q;
                rd_val[`PTS_CTRL_EN_BIT]    = en_q;
                rd_val[`PTS_CTRL_PKT_BIT]   = pkt_q;
            end
            hit(s_axi_araddr, `PTS_OFF_TX_LO):    rd_val = stamp_q[31:0];
            hit(s_axi_araddr, `PTS_OFF_TX_HI):    rd_val = stamp_q[63:32];
            hit(s_axi_araddr, `PTS_OFF_IRQ_STAT):
                rd_val[`PTS_IRQ_W-1:0] = stat_q;
            hit(s_axi_araddr, `PTS_OFF_IRQ_MASK):
                rd_val[`PTS_IRQ_W-1:0] = mask_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? PTS_RESP_OKAY : PTS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sticky events: a stamp captured, an adjustment applied
    assign evt[`PTS_IRQ_CAPTURE_BIT] = capture;
    assign evt[`PTS_IRQ_ADJUST_BIT]  = adj_go_q;

    // Write one to clear; a new event in the same cycle keeps the bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
        end else if (wr_go && hit(aw_addr_q, `PTS_OFF_IRQ_STAT)
                     && w_strb_q[0]) begin
            stat_q <= (stat_q & ~w_data_q[`PTS_IRQ_W-1:0]) | evt;
        end else begin
            stat_q <= stat_q | evt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end
endmodule : pts_stamp_top
`default_nettype wire

// ===== testbench/pts_stamp_top_props.sv
// Port-level checks for the precision-time stamp block.
// Assumes binding onto pts_stamp_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module pts_stamp_top_props (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        arst_n,
    // Write channels
    input wire logic [16:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic [16:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Transmit and interrupt
    input wire logic        tx_pkt_stamp,
    input wire logic        irq
);
    import pts_pkg::*;
    logic [16:0] ra_q;
    logic        clr_q;
    logic        arhs;
    assign arhs = s_axi_arvalid && s_axi_arready;
    // Address of the read in flight
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) ra_q <= 17'h0;
        else if (arhs) ra_q <= s_axi_araddr;
    end
    // Stamp high read seen with no pulse since; conservative on purpose
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) clr_q <= 1'b0;
        else if (tx_pkt_stamp) clr_q <= 1'b0;
        else if (arhs && s_axi_araddr == `PTS_OFF_TX_HI) clr_q <= 1'b1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ctrl_ans;
        s_axi_rvalid && ra_q == `PTS_OFF_TX_CTRL;
    endsequence
    // Answer either retires after its handshake or holds unchanged
    AST_R_HOLD: assert property (
        s_axi_rvalid |=> ($past(s_axi_rready) ? !s_axi_rvalid
                          : s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read answer not held or not retired");
    AST_B_HOLD: assert property (
        s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
                          : s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write answer not held or not retired");
    AST_R_AFTER: assert property (
        arhs |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    AST_B_AFTER: assert property (
        s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    AST_CTRL_RSVD: assert property (
        s_ctrl_ans |-> s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[31:6] == 26'h0)
        else $error("control reserved bits not zero");
    AST_VALID_CLR: assert property (
        s_ctrl_ans ##0 clr_q |-> s_axi_rdata[0] == 1'b0)
        else $error("valid flag survived stamp high read");
    AST_STAMP_OK: assert property (
        s_axi_rvalid && (ra_q == `PTS_OFF_TX_LO || ra_q == `PTS_OFF_TX_HI)
        |-> s_axi_rresp == PTS_RESP_OKAY)
        else $error("stamp read refused");
    AST_UNMAPPED: assert property (
        s_axi_rvalid && ra_q > `PTS_OFF_TX_HI && ra_q < `PTS_OFF_IRQ_STAT
        |-> s_axi_rresp == PTS_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : pts_stamp_top_props
bind pts_stamp_top pts_stamp_top_props u_props (.sys_clk, .arst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_pkt_stamp, .irq);
`default_nettype wire

// ===== testbench/pts_stamp_top_test.sv
// Self-checking bench for the precision-time stamp block.
// Assumes the package, params header and design are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module pts_stamp_top_test;
    import pts_pkg::*;
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic [16:0] awa = 17'h0;
    logic [16:0] ara = 17'h0;
    logic [31:0] wd  = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic        arv = 1'b0, rry = 1'b0, stp = 1'b0;
    logic        awr, wr_, bv, arr, rv, irq;
    logic [1:0]  br, rr, rsp;
    logic [31:0] rd;
    int          bad_count = 0, samples_checked = 0, cyc = 0, t1;
    pts_time_t   s0, s1;
    pts_word_t   al [3] = '{32'h100, 32'h50, 32'h0};
    pts_word_t   ah [3] = '{32'h0, 32'h8000_0000, 32'h1};
    pts_time_t   dl [3] = '{64'h103, 64'hffff_ffff_ffff_ffb3, 64'h1_0000_0003};

    always #12.5 sys_clk = ~sys_clk;

    pts_stamp_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .tx_pkt_stamp(stp),
        .irq(irq));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Write: both channels offered at once, bready held from the start;
    // a spare edge at the end keeps the next call from re-raising bready
    task automatic wr(input logic [16:0] a, input logic [31:0] v);
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
        end while (!bv);
        rsp = br;
        bry <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    // Read: rready held from the start, data taken at the rvalid edge
    task automatic rdd(input logic [16:0] a, output logic [31:0] v);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        v = rd;
        rsp = rr;
        rry <= 1'b0;
        @(posedge sys_clk);
    endtask : rdd

    task automatic rc(input logic [16:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'b00);
        logic [31:0] v;
        rdd(a, v);
        chk({30'h0, rsp, v}, {30'h0, er, e});
    endtask : rc

    task automatic stamp(output pts_time_t s);
        logic [31:0] lo, hi;
        rdd(`PTS_OFF_TX_LO, lo);
        rdd(`PTS_OFF_TX_HI, hi);
        s = {hi, lo};
    endtask : stamp

    // One-cycle stamp pulse; the trailing edge separates back-to-back pulses
    task automatic pulse;
        stp <= 1'b1;
        @(posedge sys_clk);
        stp <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse

    // Level interrupt trails status and mask by a cycle
    task automatic irq_is(input logic e);
        repeat (3) @(posedge sys_clk);
        chk({63'h0, irq}, {63'h0, e});
    endtask : irq_is

    task automatic results;
        $display("checks=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Watchdog; the whole run needs under five hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            rc(`PTS_OFF_TIME_LO + 17'(i * 4), 32'h0);
        end
        rc(17'h0b620, 32'h0, 2'b10);
        wr(17'h0b620, 32'hffff_ffff);
        chk({62'h0, rsp}, 64'h2);
        wr(`PTS_OFF_TX_CTRL, 32'hffff_ffff);
        rc(`PTS_OFF_TX_CTRL, 32'h30);
        wr(`PTS_OFF_INC_ATTR, 32'ha5c3_3c5a);
        rc(`PTS_OFF_INC_ATTR, 32'ha5c3_3c5a);
        wr(`PTS_OFF_TX_CTRL, 32'h20);
        pulse();
        rc(`PTS_OFF_TX_CTRL, 32'h20);
        rc(`PTS_OFF_TX_LO, 32'h0);
        wr(`PTS_OFF_TIME_HI, 32'h1234_5678);
        wr(`PTS_OFF_TIME_LO, 32'h9abc_def0);
        rc(`PTS_OFF_TIME_LO, 32'h9abc_def0);
        rc(`PTS_OFF_TIME_HI, 32'h1234_5678);
        wr(`PTS_OFF_INC_ATTR, 32'h0400_0003);
        wr(`PTS_OFF_TX_CTRL, 32'h30);
        pulse();
        pulse();
        rc(`PTS_OFF_TX_CTRL, 32'h31);
        stamp(s0);
        chk(s0, 64'h1234_5678_9abc_def0);
        rc(`PTS_OFF_TX_CTRL, 32'h30);
        repeat (40) @(posedge sys_clk);
        pulse();
        stamp(s1);
        chk(s1 - s0, 64'h3);
        for (int i = 0; i < 3; i++) begin
            wr(`PTS_OFF_ADJ_LO, al[i]);
            wr(`PTS_OFF_ADJ_HI, ah[i]);
            pulse();
            stamp(s0);
            chk(s0 - s1, dl[i]);
            s1 = s0;
        end
        wr(`PTS_OFF_TX_CTRL, 32'h10);
        t1 = cyc;
        pulse();
        stamp(s0);
        while (cyc < t1 + 40) @(posedge sys_clk);
        pulse();
        stamp(s1);
        chk(s1 - s0, 64'd30);
        rc(`PTS_OFF_IRQ_STAT, 32'h3);
        irq_is(1'b0);
        wr(`PTS_OFF_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(`PTS_OFF_IRQ_STAT, 32'h1);
        irq_is(1'b0);
        rc(`PTS_OFF_IRQ_STAT, 32'h2);
        wr(`PTS_OFF_IRQ_MASK, 32'h3);
        irq_is(1'b1);
        wr(`PTS_OFF_IRQ_STAT, 32'h2);
        irq_is(1'b0);
        results();
    end
endmodule : pts_stamp_top_test
`default_nettype wire
